// file: hw/filter_entry_pkg.sv
package filter_entry_pkg;

  // ==========================================================================
  // Widths of the matched fields.
  localparam int ADDR_W = 128;
  localparam int PORT_W = 16;
  localparam int SEQ_W = 31;
  localparam int LEN_W = 8;
  localparam int PROTO_W = 8;
  localparam int FLAG_COUNT = 4;

  // ==========================================================================
  // Register byte offsets.
  localparam logic [7:0] CTRL_OFS = 8'h00;
  localparam logic [7:0] SEQUENCE_OFS = 8'h04;
  localparam logic [7:0] PREFIX_OFS = 8'h08;
  localparam logic [7:0] SPORT_OFS = 8'h0C;
  localparam logic [7:0] DPORT_OFS = 8'h10;
  localparam logic [7:0] FLAGS_OFS = 8'h14;
  localparam logic [7:0] HIT_COUNT_OFS = 8'h18;
  localparam logic [7:0] SRC_ADDR_OFS = 8'h20;
  localparam logic [7:0] DST_ADDR_OFS = 8'h30;

  // ==========================================================================
  // Field positions inside the control, prefix and port registers.
  localparam int CTRL_ENABLE_BIT = 0;
  localparam int CTRL_ACTION_LSB = 1;
  localparam int CTRL_PROTO_ANY_BIT = 3;
  localparam int CTRL_PROTO_LSB = 4;
  localparam int CTRL_SRC_ANY_BIT = 12;
  localparam int CTRL_DST_ANY_BIT = 13;
  localparam int CTRL_SPORT_LSB = 14;
  localparam int CTRL_DPORT_LSB = 16;
  localparam int PREFIX_DST_LSB = 8;
  localparam int PORT_HI_LSB = 16;

  // ==========================================================================
  // Values after reset and fixed codes.
  localparam logic [31:0] CTRL_RESET = 32'h0000_3008;
  localparam logic [SEQ_W-1:0] SEQUENCE_RESET = 31'h0000_0001;
  localparam logic [LEN_W-1:0] PREFIX_MAX = 8'h80;
  localparam logic [PROTO_W-1:0] TCP_PROTOCOL = 8'h06;
  localparam logic [31:0] HIT_COUNT_MAX = 32'hFFFF_FFFF;

  // Forwarding action of the entry.
  typedef enum logic [1:0] {ACTION_PERMIT, ACTION_DENY, ACTION_SHUTDOWN} action_t;

  // Port criterion modes.
  localparam logic [1:0] PORT_ANY = 2'h0;
  localparam logic [1:0] PORT_SINGLE = 2'h1;
  localparam logic [1:0] PORT_RANGE = 2'h2;

  // TCP flag condition codes.
  localparam logic [1:0] FLAG_DONT_CARE = 2'h0;
  localparam logic [1:0] FLAG_SET = 2'h1;
  localparam logic [1:0] FLAG_UNSET = 2'h2;

endpackage

// file: hw/prefix_compare.sv
`timescale 1ns/1ns
module prefix_compare #(
  parameter int WIDTH = filter_entry_pkg::ADDR_W
) (
  // Criterion setup.
  input wire logic use_any,
  input wire logic [filter_entry_pkg::LEN_W-1:0] prefix_len,
  input wire logic [WIDTH-1:0] cfg_addr,
  // Address of the frame.
  input wire logic [WIDTH-1:0] frame_addr,
  // Result.
  output logic hit
);
  import filter_entry_pkg::*;

  logic [WIDTH-1:0] care_mask;

  // Bit i counted from the top takes part only while i is below the prefix length.
  for (genvar i = 0; i < WIDTH; i++) begin : g_mask
    assign care_mask[WIDTH-1-i] = (LEN_W'(i) < prefix_len);
  end

  // Any ignores the address, otherwise the leading bits must all agree.
  assign hit = use_any | (((frame_addr ^ cfg_addr) & care_mask) == '0);

endmodule

// file: hw/ipv6_frame_filter_entry.sv
// Decided for this implementation: the AHB-Lite register port and the placing of the registers.
`timescale 1ns/1ns
// Overview of operation
// - Permit match forwards frame and learns source.
// - Deny match drops the frame.
// - Shutdown action is a third selectable action.
// - Protocol any skips check, else must equal.
// - Source any ignores source address.
// - User source address must equal configured value.
// - Source prefix length limits compared leading bits.
// - Destination any ignores destination address.
// - User destination address must equal configured value.
// - Destination prefix length limits compared leading bits.
// - Source port any is don't-care.
// - Single source port must equal 16-bit value.
// - Range source port must fall within bounds.
// - Destination port any is don't-care.
// - Single destination port must equal value.
// - Range destination port must lie within bounds.
// - URG condition: set, unset or don't-care.
// - ACK condition: set, unset or don't-care.
// - PSH condition: set, unset or don't-care.
// - RST condition supports set and unset.
// - Entry carries a configurable ordering sequence value.
// - Sequence 1 to 2147483647, lower goes first.
module ipv6_frame_filter_entry (
  // Clock and reset.
  input wire logic hclk,
  input wire logic hresetn,
  // AHB-Lite slave.
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  // Parsed frame from the parser.
  input wire logic frame_valid,
  input wire logic [filter_entry_pkg::PROTO_W-1:0] frame_protocol,
  input wire logic [filter_entry_pkg::ADDR_W-1:0] frame_src_addr,
  input wire logic [filter_entry_pkg::ADDR_W-1:0] frame_dst_addr,
  input wire logic [filter_entry_pkg::PORT_W-1:0] frame_src_port,
  input wire logic [filter_entry_pkg::PORT_W-1:0] frame_dst_port,
  input wire logic [filter_entry_pkg::FLAG_COUNT-1:0] frame_tcp_flags,
  // Verdict to the forwarding pipeline.
  output logic verdict_valid,
  output logic verdict_match,
  output filter_entry_pkg::action_t verdict_action,
  output logic verdict_forward,
  output logic verdict_learn,
  output logic verdict_drop,
  output logic verdict_shutdown,
  // Entry state for the list arbiter.
  output logic entry_active,
  output logic [filter_entry_pkg::SEQ_W-1:0] entry_sequence
);
  import filter_entry_pkg::*;

  // ==========================================================================
  // Configuration state.
  logic proto_any;
  logic [PROTO_W-1:0] cfg_protocol;
  logic src_any;
  logic dst_any;
  logic [1:0] sport_mode;
  logic [1:0] dport_mode;
  action_t cfg_action;
  logic [LEN_W-1:0] src_prefix_len;
  logic [LEN_W-1:0] dst_prefix_len;
  logic [PORT_W-1:0] sport_lo;
  logic [PORT_W-1:0] sport_hi;
  logic [PORT_W-1:0] dport_lo;
  logic [PORT_W-1:0] dport_hi;
  logic [2*FLAG_COUNT-1:0] flag_cond;
  logic [31:0] src_addr_word [4];
  logic [31:0] dst_addr_word [4];
  logic [31:0] hit_count;

  // Bus data-phase state.
  logic wr_pending;
  logic [7:0] wr_offset;

  // Match terms.
  logic proto_hit;
  logic src_hit;
  logic dst_hit;
  logic sport_hit;
  logic dport_hit;
  logic flags_hit;
  logic next_match;
  logic bus_take;
  logic [31:0] read_value;

  // ==========================================================================
  // Port criterion check, shared by source and destination.
  function automatic logic port_ok(input logic [1:0] mode, input logic [PORT_W-1:0] lo,
                                   input logic [PORT_W-1:0] hi, input logic [PORT_W-1:0] port);
    unique case (mode)
      PORT_ANY: return 1'b1;
      PORT_SINGLE: return port == lo;
      PORT_RANGE: return (port >= lo) && (port <= hi);
      default: return 1'b0;
    endcase
  endfunction

  // Tri-state flag conditions; a frame flag set under unset fails the entry.
  function automatic logic flag_ok(input logic [1:0] cond, input logic bit_value);
    unique case (cond)
      FLAG_DONT_CARE: return 1'b1;
      FLAG_SET: return bit_value;
      FLAG_UNSET: return !bit_value;
      default: return 1'b1;
    endcase
  endfunction

  // Prefix length written above the address width is held at the width.
  function automatic logic [LEN_W-1:0] clamp_len(input logic [LEN_W-1:0] len);
    return (len > PREFIX_MAX) ? PREFIX_MAX : len;
  endfunction

  // ==========================================================================
  // Address comparators with prefix masks.
  prefix_compare #(.WIDTH(ADDR_W)) src_cmp (
    .use_any(src_any),
    .prefix_len(src_prefix_len),
    .cfg_addr({src_addr_word[0], src_addr_word[1], src_addr_word[2], src_addr_word[3]}),
    .frame_addr(frame_src_addr),
    .hit(src_hit)
  );
  prefix_compare #(.WIDTH(ADDR_W)) dst_cmp (
    .use_any(dst_any),
    .prefix_len(dst_prefix_len),
    .cfg_addr({dst_addr_word[0], dst_addr_word[1], dst_addr_word[2], dst_addr_word[3]}),
    .frame_addr(frame_dst_addr),
    .hit(dst_hit)
  );

  // Remaining criteria and their conjunction.
  always_comb begin
    proto_hit = proto_any || (frame_protocol == cfg_protocol);
    sport_hit = port_ok(sport_mode, sport_lo, sport_hi, frame_src_port);
    dport_hit = port_ok(dport_mode, dport_lo, dport_hi, frame_dst_port);
    flags_hit = 1'b1;
    if (frame_protocol == TCP_PROTOCOL) begin
      for (int i = 0; i < FLAG_COUNT; i++) begin
        flags_hit = flags_hit && flag_ok(flag_cond[2*i +: 2], frame_tcp_flags[i]);
      end
    end
    next_match = entry_active && proto_hit && src_hit && dst_hit && sport_hit && dport_hit
                 && flags_hit;
  end

  // ==========================================================================
  // Verdict register, one cycle after the frame is presented.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      {verdict_valid, verdict_match, verdict_forward} <= '0;
      {verdict_learn, verdict_drop, verdict_shutdown} <= '0;
      verdict_action <= ACTION_PERMIT;
    end else begin
      verdict_valid <= frame_valid;
      verdict_match <= frame_valid && next_match;
      verdict_action <= cfg_action;
      verdict_forward <= frame_valid && next_match && (cfg_action == ACTION_PERMIT);
      verdict_learn <= frame_valid && next_match && (cfg_action == ACTION_PERMIT);
      verdict_drop <= frame_valid && next_match && (cfg_action != ACTION_PERMIT);
      verdict_shutdown <= frame_valid && next_match && (cfg_action == ACTION_SHUTDOWN);
    end
  end

  // Saturating hit counter; a match in the clearing cycle still counts.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hit_count <= '0;
    end else if (frame_valid && next_match) begin
      if (wr_pending && wr_offset == HIT_COUNT_OFS) begin
        hit_count <= 32'h0000_0001;
      end else if (hit_count != HIT_COUNT_MAX) begin
        hit_count <= hit_count + 32'h0000_0001;
      end
    end else if (wr_pending && wr_offset == HIT_COUNT_OFS) begin
      hit_count <= '0;
    end
  end

  // ==========================================================================
  // Bus slave: zero wait states, always OKAY.
  assign bus_take = hsel && htrans[1] && hready;

  // Read mux; unmapped offsets read as zero.
  always_comb begin
    read_value = '0;
    unique case (haddr[7:0])
      CTRL_OFS: begin
        read_value[CTRL_ENABLE_BIT] = entry_active;
        read_value[CTRL_ACTION_LSB +: 2] = cfg_action;
        read_value[CTRL_PROTO_ANY_BIT] = proto_any;
        read_value[CTRL_PROTO_LSB +: PROTO_W] = cfg_protocol;
        read_value[CTRL_SRC_ANY_BIT] = src_any;
        read_value[CTRL_DST_ANY_BIT] = dst_any;
        read_value[CTRL_SPORT_LSB +: 2] = sport_mode;
        read_value[CTRL_DPORT_LSB +: 2] = dport_mode;
      end
      SEQUENCE_OFS: read_value[SEQ_W-1:0] = entry_sequence;
      PREFIX_OFS: read_value[15:0] = {dst_prefix_len, src_prefix_len};
      SPORT_OFS: read_value = {sport_hi, sport_lo};
      DPORT_OFS: read_value = {dport_hi, dport_lo};
      FLAGS_OFS: read_value[2*FLAG_COUNT-1:0] = flag_cond;
      HIT_COUNT_OFS: read_value = hit_count;
      default: begin
        if (haddr[7:4] == SRC_ADDR_OFS[7:4]) begin
          read_value = src_addr_word[haddr[3:2]];
        end else if (haddr[7:4] == DST_ADDR_OFS[7:4]) begin
          read_value = dst_addr_word[haddr[3:2]];
        end
      end
    endcase
  end

  // Address phase capture and read data.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pending <= 1'b0;
      wr_offset <= '0;
      hrdata <= '0;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end else begin
      wr_pending <= bus_take && hwrite;
      if (bus_take) begin
        wr_offset <= haddr[7:0];
      end
      if (bus_take && !hwrite) begin
        hrdata <= read_value;
      end
    end
  end

  // Configuration writes in the data phase.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      entry_active <= CTRL_RESET[CTRL_ENABLE_BIT];
      cfg_action <= action_t'(CTRL_RESET[CTRL_ACTION_LSB +: 2]);
      proto_any <= CTRL_RESET[CTRL_PROTO_ANY_BIT];
      cfg_protocol <= CTRL_RESET[CTRL_PROTO_LSB +: PROTO_W];
      src_any <= CTRL_RESET[CTRL_SRC_ANY_BIT];
      dst_any <= CTRL_RESET[CTRL_DST_ANY_BIT];
      sport_mode <= CTRL_RESET[CTRL_SPORT_LSB +: 2];
      dport_mode <= CTRL_RESET[CTRL_DPORT_LSB +: 2];
      {src_prefix_len, dst_prefix_len} <= '0;
      {sport_lo, sport_hi, dport_lo, dport_hi} <= '0;
      flag_cond <= '0;
      for (int i = 0; i < 4; i++) begin
        src_addr_word[i] <= '0;
        dst_addr_word[i] <= '0;
      end
    end else if (wr_pending) begin
      unique case (wr_offset)
        CTRL_OFS: begin
          entry_active <= hwdata[CTRL_ENABLE_BIT];
          if (hwdata[CTRL_ACTION_LSB +: 2] != 2'h3) begin
            cfg_action <= action_t'(hwdata[CTRL_ACTION_LSB +: 2]);
          end
          proto_any <= hwdata[CTRL_PROTO_ANY_BIT];
          cfg_protocol <= hwdata[CTRL_PROTO_LSB +: PROTO_W];
          src_any <= hwdata[CTRL_SRC_ANY_BIT];
          dst_any <= hwdata[CTRL_DST_ANY_BIT];
          sport_mode <= hwdata[CTRL_SPORT_LSB +: 2];
          dport_mode <= hwdata[CTRL_DPORT_LSB +: 2];
        end
        PREFIX_OFS: begin
          src_prefix_len <= clamp_len(hwdata[LEN_W-1:0]);
          dst_prefix_len <= clamp_len(hwdata[PREFIX_DST_LSB +: LEN_W]);
        end
        SPORT_OFS: begin
          sport_lo <= hwdata[PORT_W-1:0];
          sport_hi <= hwdata[PORT_HI_LSB +: PORT_W];
        end
        DPORT_OFS: begin
          dport_lo <= hwdata[PORT_W-1:0];
          dport_hi <= hwdata[PORT_HI_LSB +: PORT_W];
        end
        FLAGS_OFS: flag_cond <= hwdata[2*FLAG_COUNT-1:0];
        default: begin
          if (wr_offset[7:4] == SRC_ADDR_OFS[7:4]) begin
            src_addr_word[wr_offset[3:2]] <= hwdata;
          end else if (wr_offset[7:4] == DST_ADDR_OFS[7:4]) begin
            dst_addr_word[wr_offset[3:2]] <= hwdata;
          end
        end
      endcase
    end
  end

  // Sequence value; a write of zero is ignored so the value stays in range.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      entry_sequence <= SEQUENCE_RESET;
    end else if (wr_pending && wr_offset == SEQUENCE_OFS && hwdata[SEQ_W-1:0] != '0) begin
      entry_sequence <= hwdata[SEQ_W-1:0];
    end
  end

  // ==========================================================================
  // Checks on the verdict and the configuration.
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  permit_forward_a: assert property (verdict_match && verdict_action == ACTION_PERMIT
    |-> verdict_forward && verdict_learn && !verdict_drop)
    else $error("Permit match did not forward and learn.");
  deny_drop_a: assert property (verdict_match && verdict_action == ACTION_DENY
    |-> verdict_drop && !verdict_forward && !verdict_shutdown)
    else $error("Deny match did not drop.");
  shutdown_flag_a: assert property (verdict_shutdown
    |-> verdict_match && verdict_action == ACTION_SHUTDOWN && !verdict_learn)
    else $error("Shutdown verdict without shutdown match.");
  protocol_miss_a: assert property (frame_valid && !proto_any && frame_protocol != cfg_protocol
    |=> verdict_valid && !verdict_match)
    else $error("Wrong protocol matched.");
  all_any_hit_a: assert property (frame_valid && entry_active && proto_any && src_any
    && dst_any && sport_mode == PORT_ANY && dport_mode == PORT_ANY && flag_cond == '0
    |=> verdict_match)
    else $error("Entry with all criteria open failed to match.");
  src_full_miss_a: assert property (frame_valid && !src_any && src_prefix_len == PREFIX_MAX
    && frame_src_addr != src_cmp.cfg_addr |=> !verdict_match)
    else $error("Source address mismatch matched.");
  dst_full_miss_a: assert property (frame_valid && !dst_any && dst_prefix_len == PREFIX_MAX
    && frame_dst_addr != dst_cmp.cfg_addr |=> !verdict_match)
    else $error("Destination address mismatch matched.");
  prefix_zero_a: assert property ((src_prefix_len == '0 |-> src_hit)
    and (dst_prefix_len == '0 |-> dst_hit))
    else $error("Zero prefix length compared address bits.");
  sport_window_a: assert property (frame_valid && ((sport_mode == PORT_SINGLE
    && frame_src_port != sport_lo) || (sport_mode == PORT_RANGE && (frame_src_port < sport_lo
    || frame_src_port > sport_hi))) |=> !verdict_match)
    else $error("Source port outside criterion matched.");
  dport_window_a: assert property (frame_valid && ((dport_mode == PORT_SINGLE
    && frame_dst_port != dport_lo) || (dport_mode == PORT_RANGE && (frame_dst_port < dport_lo
    || frame_dst_port > dport_hi))) |=> !verdict_match)
    else $error("Destination port outside criterion matched.");
  tcp_flag_fail_a: assert property (frame_valid && frame_protocol == TCP_PROTOCOL && !flags_hit
    |=> !verdict_match)
    else $error("TCP flag condition violated but matched.");
  non_tcp_flags_a: assert property (frame_protocol != TCP_PROTOCOL |-> flags_hit)
    else $error("Flags evaluated on a non-TCP frame.");
  match_needs_all_a: assert property (verdict_match |-> $past(entry_active && proto_hit
    && src_hit && dst_hit && sport_hit && dport_hit && flags_hit && frame_valid))
    else $error("Match without every criterion hitting.");
  sequence_range_a: assert property (entry_sequence != '0
    and (wr_pending && wr_offset == SEQUENCE_OFS && hwdata[SEQ_W-1:0] != '0
    |=> entry_sequence == $past(hwdata[SEQ_W-1:0])))
    else $error("Sequence value out of range or not updated.");

  permit_cover: cover property (verdict_match && verdict_forward);
  deny_cover: cover property (verdict_match && verdict_drop && !verdict_shutdown);
  range_cover: cover property (frame_valid && sport_mode == PORT_RANGE && next_match);
  tcp_flag_cover: cover property (frame_valid && frame_protocol == TCP_PROTOCOL
    && flag_cond != '0 && next_match);

endmodule

// file: verif/frame_source.sv
`timescale 1ns/1ns
// ==========================================================================
// Parser stand-in: presents parsed frames to the entry, one per cycle.
module frame_source
  import filter_entry_pkg::*;
(
  // Clock.
  input wire logic hclk,
  // Parsed frame toward the entry.
  output logic frame_valid,
  output logic [filter_entry_pkg::PROTO_W-1:0] frame_protocol,
  output logic [filter_entry_pkg::ADDR_W-1:0] frame_src_addr,
  output logic [filter_entry_pkg::ADDR_W-1:0] frame_dst_addr,
  output logic [filter_entry_pkg::PORT_W-1:0] frame_src_port,
  output logic [filter_entry_pkg::PORT_W-1:0] frame_dst_port,
  output logic [filter_entry_pkg::FLAG_COUNT-1:0] frame_tcp_flags
);
  // Quiet bus at time zero.
  initial begin
    {frame_valid, frame_protocol, frame_src_addr, frame_dst_addr} = '0;
    {frame_src_port, frame_dst_port, frame_tcp_flags} = '0;
  end

  // Drives one frame for the cycle that follows the next edge.
  task automatic send(input logic [7:0] p, input logic [127:0] sa, input logic [127:0] da,
                      input logic [15:0] sp, input logic [15:0] dp, input logic [3:0] fl);
    @(posedge hclk);
    frame_valid <= 1'b1;
    frame_protocol <= p;
    {frame_src_addr, frame_dst_addr} <= {sa, da};
    {frame_src_port, frame_dst_port, frame_tcp_flags} <= {sp, dp, fl};
  endtask

  // Idle cycle; fields are inverted so stale values never look fresh.
  task automatic idle();
    @(posedge hclk);
    frame_valid <= 1'b0;
    frame_protocol <= ~frame_protocol;
    {frame_src_addr, frame_dst_addr} <= ~{frame_src_addr, frame_dst_addr};
    {frame_src_port, frame_dst_port, frame_tcp_flags} <=
      ~{frame_src_port, frame_dst_port, frame_tcp_flags};
  endtask
endmodule

// file: verif/ipv6_frame_filter_entry_tb.sv
`timescale 1ns/1ns
// ==========================================================================
// Self-checking bench: register bus plus a reference match model.
module ipv6_frame_filter_entry_tb;
  import filter_entry_pkg::*;
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic hsel = 1'b1;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0;
  logic hreadyout, hresp, fv, vv, vm, vf, vl, vd, vs, ea;
  logic [31:0] hrdata, ctrl, pfx, sprt, dprt, flg, rd;
  logic [7:0] fp;
  logic [127:0] fsa, fda, sad, dad, sa, da;
  logic [15:0] fsp, fdp, sp, dp;
  logic [3:0] ff;
  action_t va;
  logic [30:0] es;
  logic [7:0] expq[$];
  integer seed = 44602;
  int n_fail = 0;
  int checked = 0;
  int nhit = 0;

  // Clock of 50 ns.
  always #25 hclk = ~hclk;

  ipv6_frame_filter_entry ipv6_frame_filter_entry_inst (.hclk(hclk), .hresetn(hresetn),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2),
    .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp),
    .hrdata(hrdata), .frame_valid(fv), .frame_protocol(fp), .frame_src_addr(fsa),
    .frame_dst_addr(fda), .frame_src_port(fsp), .frame_dst_port(fdp),
    .frame_tcp_flags(ff), .verdict_valid(vv), .verdict_match(vm), .verdict_action(va),
    .verdict_forward(vf), .verdict_learn(vl), .verdict_drop(vd), .verdict_shutdown(vs),
    .entry_active(ea), .entry_sequence(es));

  frame_source frame_source_inst (.hclk(hclk), .frame_valid(fv), .frame_protocol(fp),
    .frame_src_addr(fsa), .frame_dst_addr(fda), .frame_src_port(fsp),
    .frame_dst_port(fdp), .frame_tcp_flags(ff));

  // ========================================================================
  // Reporting.
  task check(input logic [127:0] seen, input logic [127:0] exp, input string msg);
    checked++;
    if (seen !== exp) begin
      n_fail++;
      $display("CHECK FAILED at %0t: %s", $time, msg);
    end
  endtask

  task complete_run();
    $display("checks %0d, mismatches %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  // ========================================================================
  // Bus master: waits for ready under a bound.
  task wait_ready();
    int n;
    n = 0;
    @(posedge hclk);
    while (hreadyout !== 1'b1) begin
      n++;
      if (n > 16) begin
        n_fail++;
        complete_run();
      end
      @(posedge hclk);
    end
  endtask

  task bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
    haddr <= {24'h0, a};
    htrans <= 2'h2;
    hwrite <= wr;
    wait_ready();
    htrans <= 2'h0;
    hwdata <= d;
    wait_ready();
    rd = hrdata;
  endtask

  // ========================================================================
  // Reference model.
  function automatic int r(input int m);
    return int'($unsigned($random(seed)) % m);
  endfunction

  function automatic bit pmatch(input logic [1:0] md, input logic [15:0] p,
                                input logic [31:0] b);
    case (md)
      2'h0: return 1'b1;
      2'h1: return p == b[15:0];
      2'h2: return p >= b[15:0] && p <= b[31:16];
      default: return 1'b0;
    endcase
  endfunction

  function automatic bit model(input logic [7:0] p, input logic [3:0] fl);
    bit m;
    int ls;
    int ld;
    m = ctrl[0] && (ctrl[3] || p == ctrl[11:4]);
    ls = pfx[7:0] > 128 ? 128 : pfx[7:0];
    ld = pfx[15:8] > 128 ? 128 : pfx[15:8];
    for (int i = 0; i < 128; i++) begin
      if (!ctrl[12] && i < ls && sa[127-i] != sad[127-i]) m = 0;
      if (!ctrl[13] && i < ld && da[127-i] != dad[127-i]) m = 0;
    end
    m = m && pmatch(ctrl[15:14], sp, sprt) && pmatch(ctrl[17:16], dp, dprt);
    for (int f = 0; f < 4 && p == TCP_PROTOCOL; f++) begin
      if (flg[2*f+:2] == FLAG_SET && !fl[f]) m = 0;
      if (flg[2*f+:2] == FLAG_UNSET && fl[f]) m = 0;
    end
    return m;
  endfunction

  // Sends one frame and queues its expected verdict.
  task frame(input logic [7:0] p, input logic [3:0] fl);
    bit m;
    m = model(p, fl);
    nhit = nhit + int'(m);
    frame_source_inst.send(p, sa, da, sp, dp, fl);
    expq.push_back({1'b1, m, {2{m && ctrl[2:1] == 2'h0}}, m && ctrl[2:1] != 2'h0,
                    m && ctrl[2:1] == 2'h2, ctrl[2:1]});
  endtask

  task verdict();
    #1;
    check({vv, vm, vf, vl, vd, vs, va}, expq.pop_front(), "verdict");
  endtask

  // ========================================================================
  // Main sequence.
  initial begin
    repeat (5) @(posedge hclk);
    hresetn <= 1'b1;
    check(es, 31'h1, "sequence after reset");
    bus(0, CTRL_OFS, 32'h0);
    check(rd, CTRL_RESET, "control reset");
    bus(1, SEQUENCE_OFS, 32'h7FFF_FFFF);
    bus(1, SEQUENCE_OFS, 32'h0);
    bus(0, SEQUENCE_OFS, 32'h0);
    check(rd, 32'h7FFF_FFFF, "sequence read");
    check(es, 31'h7FFF_FFFF, "sequence port");
    bus(0, 8'h1C, 32'h0);
    check(rd, 32'h0, "unmapped read");
    // Entry with every criterion open; action code 3 must leave permit in place.
    ctrl = CTRL_RESET | 32'h0000_0001;
    {pfx, sprt, dprt, flg} = '0;
    {sad, dad, sa, da, sp, dp} = '0;
    bus(1, CTRL_OFS, ctrl | 32'h0000_0006);
    bus(0, CTRL_OFS, 32'h0);
    check(rd, ctrl, "action code 3 ignored");
    frame(8'h11, 4'hF);
    frame_source_inst.idle();
    verdict();
    for (int it = 0; it < 60; it++) begin
      ctrl = {14'h0, 2'(r(4)), 2'(r(4)), 1'(r(2)), 1'(r(2)),
              r(2) ? TCP_PROTOCOL : 8'(r(256)), 1'(r(2)), 2'(it % 3), 1'(r(8) != 0)};
      pfx = {16'h0, 8'(r(140)), 8'(r(140))};
      sprt = {16'(r(65536)), 16'(r(65536))};
      sprt[31:16] = sprt[15:0] + 16'(r(40));
      dprt = {16'(r(65536)), 16'(r(65536))};
      flg = 32'(r(256) & r(256));
      sad = {$random(seed), $random(seed), $random(seed), $random(seed)};
      dad = {$random(seed), $random(seed), $random(seed), $random(seed)};
      bus(1, CTRL_OFS, ctrl);
      bus(1, PREFIX_OFS, pfx);
      bus(1, SPORT_OFS, sprt);
      bus(1, DPORT_OFS, dprt);
      bus(1, FLAGS_OFS, flg);
      for (int i = 0; i < 4; i++) begin
        bus(1, SRC_ADDR_OFS + 8'(4 * i), sad[127-32*i-:32]);
        bus(1, DST_ADDR_OFS + 8'(4 * i), dad[127-32*i-:32]);
      end
      check(ea, ctrl[0], "entry active");
      bus(1, HIT_COUNT_OFS, 32'h0);
      nhit = 0;
      for (int k = 0; k < 8; k++) begin
        sa = sad ^ (r(2) ? 128'h0 : 128'h1 << r(128));
        da = dad ^ (r(2) ? 128'h0 : 128'h1 << r(128));
        sp = (r(2) ? sprt[15:0] : sprt[31:16]) + 16'(r(4)) - 16'h1;
        dp = (r(2) ? dprt[15:0] : dprt[31:16]) + 16'(r(4)) - 16'h1;
        frame(r(2) ? ctrl[11:4] : (r(2) ? TCP_PROTOCOL : 8'(r(256))), 4'(r(16)));
        if (k > 0) verdict();
      end
      frame_source_inst.idle();
      verdict();
      bus(0, HIT_COUNT_OFS, 32'h0);
      check(rd, 32'(nhit), "hit count");
    end
    complete_run();
  end

  // Cuts a hang short.
  initial begin
    #1000000;
    n_fail++;
    complete_run();
  end
endmodule
